/* File: logic/rtcirq_pkg.sv */
package rtcirq_pkg;

  // Register map
  localparam logic [3:0] RTCIRQ_ADDR_CS1 = 4'h0;
  localparam logic [3:0] RTCIRQ_ADDR_CS2 = 4'h1;
  localparam logic [7:0] RTCIRQ_CS1_RST  = 8'h00;
  localparam logic [7:0] RTCIRQ_CS2_RST  = 8'h00;

  // Serial bus framing
  localparam logic [3:0] RTCIRQ_BITS_BYTE = 4'h8;

  // Timer source clock select codes
  localparam logic [1:0] RTCIRQ_SRC_4096 = 2'h0;
  localparam logic [1:0] RTCIRQ_SRC_64   = 2'h1;

  // Pulse timing, derived from the system clock
  localparam int unsigned RTCIRQ_CLK_HZ      = 10_000_000;
  localparam int unsigned RTCIRQ_PER_8192_HZ = 8192;
  localparam int unsigned RTCIRQ_PER_4096_HZ = 4096;
  localparam int unsigned RTCIRQ_PER_128_HZ  = 128;
  localparam int unsigned RTCIRQ_PER_64_HZ   = 64;
  localparam int unsigned RTCIRQ_CYC_8192    = RTCIRQ_CLK_HZ / RTCIRQ_PER_8192_HZ;
  localparam int unsigned RTCIRQ_CYC_4096    = RTCIRQ_CLK_HZ / RTCIRQ_PER_4096_HZ;
  localparam int unsigned RTCIRQ_CYC_128     = RTCIRQ_CLK_HZ / RTCIRQ_PER_128_HZ;
  localparam int unsigned RTCIRQ_CYC_64      = RTCIRQ_CLK_HZ / RTCIRQ_PER_64_HZ;
  localparam int unsigned RTCIRQ_PULSE_W     = 18;

  // First control register layout
  typedef struct packed {
    logic       test_mode;
    logic       rsvd6;
    logic       halt;
    logic       rsvd4;
    logic       por_override_allow;
    logic [2:0] rsvd2_0;
  } rtcirq_cs1_t;

  // Second control register layout
  typedef struct packed {
    logic [2:0] rsvd7_5;
    logic       irq_pulse_mode;
    logic       alarm_event_flag;
    logic       timer_event_flag;
    logic       alarm_irq_enable;
    logic       timer_irq_enable;
  } rtcirq_cs2_t;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_AACK,
    ST_PTR,
    ST_PACK,
    ST_WDATA,
    ST_WACK,
    ST_RDATA,
    ST_RACK
  } rtcirq_state_t;

endpackage

/* File: logic/rtcirq_sync.sv */
`timescale 1ns/1ps
module rtcirq_sync
  import rtcirq_pkg::*;
#(
  parameter int W = 2
) (
  input  wire logic         clk_sys,
  input  wire logic         rstn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      s1_ff <= '1;
      s2_ff <= '1;
    end else begin
      s1_ff <= d;
      s2_ff <= s1_ff;
    end
  end

  assign q = s2_ff;

endmodule // rtcirq_sync

/* File: logic/rtcirq_pulse.sv */
`timescale 1ns/1ps
module rtcirq_pulse
  import rtcirq_pkg::*;
#(
  parameter int unsigned CYC_128 = RTCIRQ_CYC_128,
  parameter int unsigned CYC_64  = RTCIRQ_CYC_64
) (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       start,
  input  wire logic [1:0] src_sel,
  input  wire logic [7:0] count,
  output logic            active
);

  logic [RTCIRQ_PULSE_W-1:0] cnt_ff;
  logic [RTCIRQ_PULSE_W-1:0] nxt_cnt;
  logic [RTCIRQ_PULSE_W-1:0] len;

  // Pulse length from source clock and loaded count
  always_comb begin
    if (src_sel == RTCIRQ_SRC_4096) begin
      len = (count == 8'h01) ? RTCIRQ_PULSE_W'(RTCIRQ_CYC_8192) : RTCIRQ_PULSE_W'(RTCIRQ_CYC_4096); // RULE13
    end else if (src_sel == RTCIRQ_SRC_64) begin
      len = (count == 8'h01) ? RTCIRQ_PULSE_W'(CYC_128) : RTCIRQ_PULSE_W'(CYC_64); // RULE13
    end else begin
      len = RTCIRQ_PULSE_W'(CYC_64); // RULE13
    end
    nxt_cnt = cnt_ff;
    if (start) begin
      nxt_cnt = len;
    end else if (cnt_ff != '0) begin
      nxt_cnt = cnt_ff - RTCIRQ_PULSE_W'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign active = (cnt_ff != '0);

endmodule // rtcirq_pulse

/* File: logic/rtcirq_top.sv */
// Contract
// RULE1 - Halt bit 5 of first register clears divider chain and stops timekeeping.
// RULE2 - Clock output keeps its 32.768 kHz frequency while timekeeping is halted.
// RULE3 - Bit 3 zero keeps the power-on reset override disabled.
// RULE4 - Bit 3 one permits the power-on reset override to be enabled.
// RULE5 - Unused control bits reset to zero; software writes them as zero.
// RULE6 - Alarm match sets the alarm event flag, bit 3 of second register.
// RULE7 - Timer countdown end sets the timer event flag, bit 2.
// RULE8 - Event flags hold once set, changing only by register write.
// RULE9 - Writing second register ANDs each flag with written bit.
// RULE10 - Bits 1 and 0 enable alarm and timer interrupt sources.
// RULE11 - Interrupt output is OR of enabled alarm and enabled timer conditions.
// RULE12 - Level mode: interrupt follows timer flag, gated by its enable.
// RULE13 - Pulse mode: pulse length set by source clock and count.
// RULE14 - Pulse mode: enabled alarm flag holds interrupt permanently active.
// RULE15 - Pulse mode: timer flag and interrupt assert together.
// RULE16 - Pulse length uses loaded count; zero count keeps timer stopped.
// RULE17 - Cleared alarm flag sets again only when time increments into match.
// RULE18 - Interrupt output is active low open drain.
`timescale 1ns/1ps
module rtcirq_top
  import rtcirq_pkg::*;
#(
  parameter logic [6:0]  DEV_ADDR = 7'h5a,
  parameter int unsigned CYC_128  = RTCIRQ_CYC_128,
  parameter int unsigned CYC_64   = RTCIRQ_CYC_64
) (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  input  wire logic       time_tick,
  input  wire logic       alarm_match,
  input  wire logic       timer_done,
  input  wire logic [1:0] timer_src_sel,
  input  wire logic [7:0] timer_count,
  output logic            div_halt,
  output logic            clock_output_pin_keep_32k,
  output logic            por_override_allow,
  output logic            irq_n_o,
  output logic            irq_n_oe
);

  // Bus front end
  logic [1:0]    pins_s;
  logic          scl_s;
  logic          sda_s;
  logic          scl_d_ff;
  logic          sda_d_ff;
  logic          bus_start;
  logic          bus_stop;
  logic          scl_rise;
  logic          scl_fall;

  // Bus state
  rtcirq_state_t st_ff;
  rtcirq_state_t nxt_st;
  logic [3:0]    bits_ff;
  logic [3:0]    nxt_bits;
  logic [7:0]    sh_ff;
  logic [7:0]    nxt_sh;
  logic          drv_ff;
  logic          nxt_drv;
  logic [3:0]    ptr_ff;
  logic [3:0]    nxt_ptr;
  logic          rw_ff;
  logic          nxt_rw;
  logic [7:0]    rd_byte;
  logic          wr_en;
  logic [3:0]    wr_addr;
  logic [7:0]    wr_data;

  // Register state
  rtcirq_cs1_t   cs1_ff;
  rtcirq_cs1_t   nxt_cs1;
  rtcirq_cs2_t   cs2_ff;
  rtcirq_cs2_t   nxt_cs2;
  logic          af_set;
  logic          tf_set;
  logic          pulse_active;
  logic          irq_alarm;
  logic          irq_timer;

  function automatic logic [3:0] ptr_inc(input logic [3:0] p);
    ptr_inc = p + 4'h1;
  endfunction

  function automatic logic [7:0] rd_reg(input logic [3:0] a, input rtcirq_cs1_t c1, input rtcirq_cs2_t c2);
    if (a == RTCIRQ_ADDR_CS1) begin
      rd_reg = c1;
    end else if (a == RTCIRQ_ADDR_CS2) begin
      rd_reg = c2;
    end else begin
      rd_reg = 8'h00;
    end
  endfunction

  rtcirq_sync #(
    .W(2)
  ) u_sync (
    .clk_sys(clk_sys),
    .rstn   (rstn),
    .d      ({scl_i, sda_i}),
    .q      (pins_s)
  );

  assign scl_s     = pins_s[1];
  assign sda_s     = pins_s[0];
  assign bus_start = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  assign bus_stop  = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
  assign scl_rise  = scl_s & ~scl_d_ff;
  assign scl_fall  = ~scl_s & scl_d_ff;
  assign rd_byte   = rd_reg(ptr_ff, cs1_ff, cs2_ff);

  // Serial slave: address, pointer, auto-incremented data bytes
  always_comb begin
    nxt_st   = st_ff;
    nxt_bits = bits_ff;
    nxt_sh   = sh_ff;
    nxt_drv  = drv_ff;
    nxt_ptr  = ptr_ff;
    nxt_rw   = rw_ff;
    wr_en    = 1'b0;
    wr_addr  = ptr_ff;
    wr_data  = sh_ff;
    if (bus_stop) begin
      nxt_st  = ST_IDLE;
      nxt_drv = 1'b0;
    end else if (bus_start) begin
      nxt_st   = ST_ADDR;
      nxt_bits = 4'h0;
      nxt_drv  = 1'b0;
    end else if (scl_rise) begin
      unique case (st_ff)
        ST_ADDR, ST_PTR, ST_WDATA: begin
          nxt_sh   = {sh_ff[6:0], sda_s};
          nxt_bits = bits_ff + 4'h1;
        end
        ST_RDATA: begin
          nxt_bits = bits_ff + 4'h1;
        end
        ST_RACK: begin
          if (sda_s) begin
            nxt_st = ST_IDLE;
          end
        end
        ST_IDLE, ST_AACK, ST_PACK, ST_WACK: begin
        end
      endcase
    end else if (scl_fall) begin
      unique case (st_ff)
        ST_ADDR: begin
          if (bits_ff == RTCIRQ_BITS_BYTE) begin
            if (sh_ff[7:1] == DEV_ADDR) begin
              nxt_st  = ST_AACK;
              nxt_drv = 1'b1;
              nxt_rw  = sh_ff[0];
            end else begin
              nxt_st = ST_IDLE;
            end
          end
        end
        ST_AACK: begin
          nxt_bits = 4'h0;
          if (rw_ff) begin
            nxt_st  = ST_RDATA;
            nxt_sh  = rd_byte;
            nxt_drv = ~rd_byte[7];
          end else begin
            nxt_st  = ST_PTR;
            nxt_drv = 1'b0;
          end
        end
        ST_PTR: begin
          if (bits_ff == RTCIRQ_BITS_BYTE) begin
            nxt_ptr = sh_ff[3:0];
            nxt_st  = ST_PACK;
            nxt_drv = 1'b1;
          end
        end
        ST_PACK, ST_WACK: begin
          nxt_st   = ST_WDATA;
          nxt_bits = 4'h0;
          nxt_drv  = 1'b0;
        end
        ST_WDATA: begin
          if (bits_ff == RTCIRQ_BITS_BYTE) begin
            wr_en   = 1'b1;
            nxt_ptr = ptr_inc(ptr_ff);
            nxt_st  = ST_WACK;
            nxt_drv = 1'b1;
          end
        end
        ST_RDATA: begin
          if (bits_ff == RTCIRQ_BITS_BYTE) begin
            nxt_st  = ST_RACK;
            nxt_drv = 1'b0;
            nxt_ptr = ptr_inc(ptr_ff);
          end else begin
            nxt_sh  = {sh_ff[6:0], 1'b0};
            nxt_drv = ~sh_ff[6];
          end
        end
        ST_RACK: begin
          nxt_st   = ST_RDATA;
          nxt_bits = 4'h0;
          nxt_sh   = rd_byte;
          nxt_drv  = ~rd_byte[7];
        end
        ST_IDLE: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
      st_ff    <= ST_IDLE;
      bits_ff  <= 4'h0;
      sh_ff    <= 8'h00;
      drv_ff   <= 1'b0;
      ptr_ff   <= 4'h0;
      rw_ff    <= 1'b0;
    end else begin
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
      st_ff    <= nxt_st;
      bits_ff  <= nxt_bits;
      sh_ff    <= nxt_sh;
      drv_ff   <= nxt_drv;
      ptr_ff   <= nxt_ptr;
      rw_ff    <= nxt_rw;
    end
  end

  // Event sources
  assign af_set = time_tick & alarm_match; // RULE6 RULE17
  assign tf_set = timer_done & (timer_count != 8'h00); // RULE7 RULE16

  // Control and status registers
  always_comb begin
    nxt_cs1 = cs1_ff;
    nxt_cs2 = cs2_ff;
    if (wr_en && (wr_addr == RTCIRQ_ADDR_CS1)) begin
      nxt_cs1         = rtcirq_cs1_t'(wr_data);
      nxt_cs1.rsvd6   = 1'b0; // RULE5
      nxt_cs1.rsvd4   = 1'b0; // RULE5
      nxt_cs1.rsvd2_0 = 3'h0; // RULE5
    end
    if (wr_en && (wr_addr == RTCIRQ_ADDR_CS2)) begin
      nxt_cs2.rsvd7_5          = 3'h0; // RULE5
      nxt_cs2.irq_pulse_mode   = wr_data[4];
      nxt_cs2.alarm_irq_enable = wr_data[1];
      nxt_cs2.timer_irq_enable = wr_data[0];
      nxt_cs2.alarm_event_flag = cs2_ff.alarm_event_flag & wr_data[3]; // RULE9
      nxt_cs2.timer_event_flag = cs2_ff.timer_event_flag & wr_data[2]; // RULE9
    end
    // Set wins over a clearing write
    nxt_cs2.alarm_event_flag = nxt_cs2.alarm_event_flag | af_set; // RULE6 RULE8
    nxt_cs2.timer_event_flag = nxt_cs2.timer_event_flag | tf_set; // RULE7 RULE8
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      cs1_ff <= rtcirq_cs1_t'(RTCIRQ_CS1_RST); // RULE5
      cs2_ff <= rtcirq_cs2_t'(RTCIRQ_CS2_RST); // RULE5
    end else begin
      cs1_ff <= nxt_cs1;
      cs2_ff <= nxt_cs2;
    end
  end

  // Timer pulse starts on the same edge that sets the flag
  rtcirq_pulse #(
    .CYC_128(CYC_128),
    .CYC_64 (CYC_64)
  ) u_pulse (
    .clk_sys(clk_sys),
    .rstn   (rstn),
    .start  (tf_set), // RULE15
    .src_sel(timer_src_sel),
    .count  (timer_count), // RULE16
    .active (pulse_active)
  );

  // Interrupt combine
  assign irq_alarm = cs2_ff.alarm_event_flag & cs2_ff.alarm_irq_enable; // RULE10 RULE14
  assign irq_timer = cs2_ff.timer_irq_enable & // RULE10
                     (cs2_ff.irq_pulse_mode ? pulse_active // RULE13 RULE15
                                            : cs2_ff.timer_event_flag); // RULE12

  assign irq_n_o            = 1'b0; // RULE18
  assign irq_n_oe           = irq_alarm | irq_timer; // RULE11 RULE18
  assign sda_o              = 1'b0;
  assign sda_oe             = drv_ff;
  assign div_halt           = cs1_ff.halt; // RULE1
  assign clock_output_pin_keep_32k    = cs1_ff.halt; // RULE2
  assign por_override_allow = cs1_ff.por_override_allow; // RULE3 RULE4

endmodule // rtcirq_top

/* File: testbench/rtcirq_top_monitor.sv */
`timescale 1ns/1ps
module rtcirq_top_monitor
  import rtcirq_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rstn,
  input wire logic       scl_i,
  input wire logic       time_tick,
  input wire logic       alarm_match,
  input wire logic       timer_done,
  input wire logic [7:0] timer_count,
  input wire logic       div_halt,
  input wire logic       clock_output_pin_keep_32k,
  input wire logic       por_override_allow,
  input wire logic       irq_n_o,
  input wire logic       irq_n_oe
);
  logic [3:0] q_ff;
  logic [3:0] nxt_q;
  logic       scl_ff;
  logic       nxt_scl;
  logic       quiet;
  // Bus idle long enough that no register write can land
  always_comb begin
    nxt_scl = scl_i;
    nxt_q   = (scl_i != scl_ff) ? 4'h0 : q_ff + {3'h0, q_ff != 4'hf};
  end
  always_ff @(posedge clk_sys) begin
    scl_ff <= rstn ? nxt_scl : 1'b1;
    q_ff   <= rstn ? nxt_q : 4'h0;
  end
  assign quiet = q_ff >= 4'hc;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  chk_pin_low: assert property (irq_n_o == 1'b0)
    else $error("irq pin value not low");
  chk_halt_keeps_clk: assert property (clock_output_pin_keep_32k == div_halt)
    else $error("clock keep differs from halt");
  chk_halt_by_write: assert property (quiet |-> $stable(div_halt))
    else $error("halt moved without write");
  chk_por_by_write: assert property (quiet |-> $stable(por_override_allow))
    else $error("override moved without write");
  chk_irq_rise_cause: assert property (quiet && $rose(irq_n_oe) |->
    $past(timer_done) || ($past(time_tick) && $past(alarm_match))) else $error("irq rose without event");
  chk_zero_count: assert property (quiet && timer_done && timer_count == 8'h00 &&
    !time_tick && !irq_n_oe |=> !irq_n_oe) else $error("zero count raised irq");
  chk_event_keeps: assert property (quiet && timer_done && timer_count != 8'h00 &&
    irq_n_oe |=> irq_n_oe) else $error("timer event dropped irq");
  chk_pulse_min: assert property (quiet && $rose(irq_n_oe) && $past(timer_done) |->
    (irq_n_oe || !quiet) [*8]) else $error("irq pulse too short");
endmodule // rtcirq_top_monitor
bind rtcirq_top rtcirq_top_monitor mon (.clk_sys, .rstn, .scl_i, .time_tick, .alarm_match, .timer_done,
  .timer_count, .div_halt, .clock_output_pin_keep_32k, .por_override_allow, .irq_n_o, .irq_n_oe);

/* File: testbench/rtcirq_host.sv */
`timescale 1ns/1ps
module rtcirq_host
  import rtcirq_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h5a
) (
  input  wire logic clk_sys,
  input  wire logic sda,
  output logic      scl,
  output logic      m_oe
);
  logic [7:0] junk;
  logic       ack;
  initial begin
    scl  = 1'b1;
    m_oe = 1'b0;
  end
  task automatic w();
    repeat (6) @(posedge clk_sys);
  endtask
  // Data moves only while the clock is low
  task automatic bt(input logic b, output logic r);
    w();
    m_oe <= !b;
    w();
    scl <= 1'b1;
    w();
    w();
    r = sda;
    scl <= 1'b0;
  endtask
  task automatic xb(input logic [7:0] d, input logic last, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) bt(d[i], r[i]);
    bt(last, ack);
  endtask
  task automatic sta();
    w();
    m_oe <= 1'b0;
    w();
    scl <= 1'b1;
    w();
    m_oe <= 1'b1;
    w();
    scl <= 1'b0;
  endtask
  task automatic sto();
    w();
    m_oe <= 1'b1;
    w();
    scl <= 1'b1;
    w();
    m_oe <= 1'b0;
    w();
  endtask
  task automatic wr(input logic [3:0] p, input logic [7:0] d);
    sta();
    xb({DEV_ADDR, 1'b0}, 1'b1, junk);
    xb({4'h0, p}, 1'b1, junk);
    xb(d, 1'b1, junk);
    sto();
  endtask
  task automatic rd(input logic [3:0] p, output logic [7:0] d);
    sta();
    xb({DEV_ADDR, 1'b0}, 1'b1, junk);
    xb({4'h0, p}, 1'b1, junk);
    sta();
    xb({DEV_ADDR, 1'b1}, 1'b1, junk);
    xb(8'hff, 1'b1, d);
    sto();
  endtask
endmodule // rtcirq_host

/* File: testbench/rtcirq_top_test.sv */
`timescale 1ns/1ps
module rtcirq_top_test
  import rtcirq_pkg::*;
;
  localparam int unsigned C128 = 40;
  localparam int unsigned C64  = 80;
  logic        clk_sys     = 1'b0;
  logic        rstn        = 1'b0;
  logic        time_tick   = 1'b0;
  logic        alarm_match = 1'b0;
  logic        timer_done  = 1'b0;
  logic [1:0]  src         = 2'h0;
  logic [7:0]  cnt         = 8'h00;
  logic        scl, m_oe, sda_o, sda_oe, div_halt, keep, por, irq_n_o, irq_n_oe;
  wire         sda = (sda_oe ? sda_o : 1'b1) & !m_oe;
  wire  [15:0] st  = {12'h000, div_halt, keep, por, irq_n_oe && (irq_n_o == 1'b0)};
  int          n_fail    = 0;
  int          cmp_count = 0;
  int          cyc       = 0;
  int          n;
  logic [7:0]  rv;
  logic [1:0]  src_t [6] = '{RTCIRQ_SRC_4096, RTCIRQ_SRC_4096, RTCIRQ_SRC_64, RTCIRQ_SRC_64, 2'h2, 2'h3};
  logic [7:0]  cnt_t [6] = '{8'h01, 8'h02, 8'h01, 8'h05, 8'h01, 8'h01};
  int unsigned len_t [6] = '{RTCIRQ_CYC_8192, RTCIRQ_CYC_4096, C128, C64, C64, C64};
  always #50 clk_sys = !clk_sys;
  rtcirq_top #(.CYC_128(C128), .CYC_64(C64)) dut (.clk_sys(clk_sys), .rstn(rstn), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .time_tick(time_tick), .alarm_match(alarm_match), .timer_done(timer_done),
    .timer_src_sel(src), .timer_count(cnt), .div_halt(div_halt), .clock_output_pin_keep_32k(keep),
    .por_override_allow(por), .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe));
  rtcirq_host host (.clk_sys(clk_sys), .sda(sda), .scl(scl), .m_oe(m_oe));
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic rc(input logic [3:0] p, input logic [7:0] e);
    host.rd(p, rv);
    chk({8'h00, rv}, {8'h00, e});
  endtask
  // Event strobe, ends just after the edge that samples it
  task automatic ev(input logic t, input logic a, input logic d, input logic [1:0] s, input logic [7:0] c);
    repeat (16) @(posedge clk_sys);
    src <= s;
    cnt <= c;
    alarm_match <= a;
    @(posedge clk_sys);
    time_tick <= t;
    timer_done <= d;
    @(posedge clk_sys);
    time_tick <= 1'b0;
    timer_done <= 1'b0;
    #1;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail = n_fail + 1;
      end_sim();
    end
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    chk(st, 16'h0000);
    rc(4'h0, 8'h00);
    rc(4'h1, 8'h00);
    host.wr(4'h0, 8'hff);
    rc(4'h0, 8'ha8);
    chk(st, 16'h000e);
    host.wr(4'h0, 8'h00);
    chk(st, 16'h0000);
    host.wr(4'h1, 8'h03);
    ev(1'b0, 1'b0, 1'b1, 2'h0, 8'h00);
    chk(st, 16'h0000);
    ev(1'b1, 1'b1, 1'b0, 2'h0, 8'h00);
    chk(st, 16'h0001);
    ev(1'b0, 1'b1, 1'b1, 2'h0, 8'h03);
    rc(4'h1, 8'h0f);
    host.wr(4'h1, 8'h0b);
    rc(4'h1, 8'h0b);
    host.wr(4'h1, 8'h08);
    chk(st, 16'h0000);
    rc(4'h1, 8'h08);
    host.wr(4'h1, 8'h02);
    ev(1'b0, 1'b1, 1'b0, 2'h0, 8'h03);
    chk(st, 16'h0000);
    ev(1'b1, 1'b1, 1'b0, 2'h0, 8'h03);
    chk(st, 16'h0001);
    host.wr(4'h1, 8'h01);
    ev(1'b0, 1'b0, 1'b1, 2'h0, 8'h01);
    // Wait past the pulse so only the level flag can hold the pin
    repeat (1300) @(posedge clk_sys);
    #1;
    chk(st, 16'h0001);
    host.wr(4'h1, 8'h11);
    for (int i = 0; i < 6; i++) begin
      ev(1'b0, 1'b0, 1'b1, src_t[i], cnt_t[i]);
      n = 0;
      while (irq_n_oe === 1'b1 && n < 3000) begin
        @(posedge clk_sys);
        #1;
        n++;
      end
      chk(n[15:0], len_t[i][15:0]);
    end
    host.wr(4'h1, 8'h13);
    ev(1'b1, 1'b1, 1'b0, 2'h0, 8'h01);
    repeat (100) @(posedge clk_sys);
    #1;
    chk(st, 16'h0001);
    end_sim();
  end
endmodule // rtcirq_top_test
